//--- rtl/sysctl_params.svh
// Constants for the system power, clock and reset controller.
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH
`define MODE_RUN 2'h0
`define MODE_STANDBY 2'h1
`define MODE_SLEEP 2'h2
`define MODE_DEEP 2'h3
`define SRC_FAST_XTAL 2'h0
`define SRC_SLOW_XTAL 2'h1
`define SRC_RC_FAST 2'h2
`define SRC_RC_SLOW 2'h3
`define CLKSEL_RESET 5'h09
`define RESET_VECTOR 16'h0000
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define NUM_IRQ 22
`define CAUSE_POR 3'h0
`define CAUSE_WAKE_SLEEP 3'h1
`define CAUSE_WAKE_DEEP 3'h2
`define CAUSE_WATCHDOG 3'h3
`define CAUSE_SOFTWARE 3'h4
`define SWITCH_OLD_EDGES 2'h2
`define SWITCH_NEW_EDGES 2'h2
`define FLL_STEP 8'h01
`define TRIM_RESET 8'h80
`endif

//--- rtl/sysctl_pkg.sv
// Types for the system power, clock and reset controller.
package sysctl_pkg;
  typedef enum logic [1:0] {sw_idle, sw_wait_start, sw_old, sw_new} switch_state_e;
  typedef enum logic [1:0] {pw_run, pw_standby, pw_sleep, pw_deep} power_state_e;
endpackage

//--- rtl/irq_vector_select.sv
// Interrupt priority resolution and vector address generation.
`timescale 1ns/10ps
`default_nettype none
`include "sysctl_params.svh"
module irq_vector_select #(
  parameter int N = `NUM_IRQ
) (
  // Sources and configuration
  input wire logic [N-1:0] i_pending,
  input wire logic [N-1:0] i_enable,
  input wire logic [N-1:0] i_high_prio,
  // Result
  output logic o_valid,
  output logic [4:0] o_index,
  output logic [15:0] o_vector
);
  logic [N-1:0] active;
  logic [N-1:0] active_hi;
  logic found_hi;
  logic found_lo;
  logic [4:0] idx_hi;
  logic [4:0] idx_lo;

  assign active = i_pending & i_enable;
  assign active_hi = active & i_high_prio;

  // Lowest-numbered source wins within each level.
  always_comb begin
    found_hi = 1'b0;
    found_lo = 1'b0;
    idx_hi = 5'h00;
    idx_lo = 5'h00;
    for (int k = N - 1; k >= 0; k--) begin
      if (active_hi[k]) begin
        found_hi = 1'b1;
        idx_hi = 5'(k);
      end
      if (active[k]) begin
        found_lo = 1'b1;
        idx_lo = 5'(k);
      end
    end
  end

  assign o_valid = found_hi | found_lo;
  assign o_index = found_hi ? idx_hi : idx_lo;
  assign o_vector = `VEC_BASE + ({11'h000, o_index} << 3);
endmodule
`default_nettype wire

//--- rtl/system_power_clock_reset_ctrl.sv
// System power mode, clock selection, clock monitor, trim loop and reset controller.
//
// Functional notes
// - Run mode keeps core and peripherals clocked.
// - Standby halts core, resumes on enabled interrupt.
// - Sleep powers down core and peripherals, keeps radio on.
// - Sleep retains each RAM half per setting.
// - Sleep exits on port or controller interrupt.
// - Deepest mode keeps only four scratch bytes.
// - Deepest mode exits only on wake pin low.
// - Four selectable system clock sources.
// - Power-of-two prescaler divides selected source.
// - Reset default is fast RC divided two.
// - Glitch-free switch, two old, two new edges.
// - Switch waits for new oscillator startup.
// - Status shows switch pending or complete.
// - Monitor restores default clock on stall.
// - Loop trims RC toward running reference.
// - Trim holds when reference stops.
// - Core fetch starts at address zero.
// - Reset clears all but scratch registers.
// - Core reset sources: pin, wake, watchdog, software.
// - Last reset cause is readable.
// - 22 sources with enable and priority.
// - Vectors from 0x0003 through 0x00ab.
`timescale 1ns/10ps
`default_nettype none
`include "sysctl_params.svh"
module system_power_clock_reset_ctrl
  import sysctl_pkg::*;
#(
  parameter int PRESCALE_W = 3,
  parameter int MON_W = 16,
  parameter int N_IRQ = `NUM_IRQ
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Power mode control
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_ram_retain,
  output logic [1:0] o_power_mode,
  output logic o_cpu_run,
  output logic o_periph_on,
  output logic o_periph_keep,
  output logic o_radio_on,
  output logic [1:0] o_ram_on,
  // Wake sources
  input wire logic i_deep_wake_pin,
  input wire logic i_port_irq,
  input wire logic i_ctrl_irq,
  // Reset sources and core reset
  input wire logic i_watchdog_rst,
  input wire logic i_software_rst,
  output logic o_core_reset,
  output logic [15:0] o_reset_vector,
  output logic [2:0] o_reset_cause,
  // Clock selection
  input wire logic i_clksel_wr,
  input wire logic [1:0] i_clksel_src,
  input wire logic [PRESCALE_W-1:0] i_clksel_div,
  input wire logic [3:0] i_osc_tick,
  input wire logic [3:0] i_osc_ready,
  output logic [1:0] o_clk_src,
  output logic [PRESCALE_W-1:0] o_clk_div,
  output logic [3:0] o_osc_request,
  output logic o_clk_gate,
  output logic o_clk_switching,
  // Clock monitor
  input wire logic [MON_W-1:0] i_mon_limit,
  input wire logic i_mon_enable,
  input wire logic i_sysclk_edge,
  output logic o_mon_tripped,
  // Frequency-locked loop
  input wire logic i_fll_enable,
  input wire logic i_ref_tick,
  input wire logic [15:0] i_fll_target,
  output logic [7:0] o_rc_trim,
  // Scratch words
  input wire logic i_scratch_wr,
  input wire logic [1:0] i_scratch_sel,
  input wire logic [7:0] i_scratch_data,
  output logic [31:0] o_scratch,
  // Interrupts
  input wire logic [N_IRQ-1:0] i_irq_pending,
  input wire logic [N_IRQ-1:0] i_irq_enable,
  input wire logic [N_IRQ-1:0] i_irq_high,
  output logic o_irq_valid,
  output logic [4:0] o_irq_index,
  output logic [15:0] o_irq_vector
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  logic [5:0] sync_prev;
  logic wake_n;
  logic [3:0] tick_seen;
  logic ref_edge;
  logic sys_edge;
  logic [3:0] osc_ready_s;
  // Reset values match the idle pin levels, so no false edge follows reset.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync_a <= 11'h400;
      sync_b <= 11'h400;
      sync_prev <= 6'h00;
    end else begin
      sync_a <= {i_deep_wake_pin, i_ref_tick, i_sysclk_edge, i_osc_ready, i_osc_tick};
      sync_b <= sync_a;
      sync_prev <= {sync_b[9:8], sync_b[3:0]};
    end
  end

  assign wake_n = sync_b[10];
  assign tick_seen = sync_b[3:0] & ~sync_prev[3:0];
  assign ref_edge = sync_b[9] & ~sync_prev[5];
  assign sys_edge = sync_b[8] ^ sync_prev[4];
  assign osc_ready_s = sync_b[7:4] | 4'hc;

  // ****************************************
  // Power modes
  // ****************************************
  power_state_e pstate;
  logic wake_any;
  logic wake_sleep;
  logic wake_pulse_sleep;
  logic wake_pulse_deep;
  assign wake_any = o_irq_valid;
  assign wake_sleep = i_port_irq | i_ctrl_irq;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pstate <= pw_run;
    end else begin
      case (pstate)
        pw_run: begin
          if (i_mode_wr) begin
            case (i_mode)
              `MODE_STANDBY: pstate <= pw_standby;
              `MODE_SLEEP: pstate <= pw_sleep;
              `MODE_DEEP: pstate <= pw_deep;
              default: pstate <= pw_run;
            endcase
          end
        end
        pw_standby: if (wake_any) pstate <= pw_run;
        pw_sleep: if (wake_sleep) pstate <= pw_run;
        pw_deep: if (!wake_n) pstate <= pw_run;
        default: pstate <= pw_run;
      endcase
    end
  end
  assign wake_pulse_sleep = (pstate == pw_sleep) && wake_sleep;
  assign wake_pulse_deep = (pstate == pw_deep) && !wake_n;
  always_comb begin
    o_power_mode = `MODE_RUN;
    o_cpu_run = 1'b1;
    o_periph_on = 1'b1;
    o_periph_keep = 1'b1;
    o_radio_on = 1'b1;
    o_ram_on = 2'h3;
    case (pstate)
      pw_standby: begin
        o_power_mode = `MODE_STANDBY;
        o_cpu_run = 1'b0;
      end
      pw_sleep: begin
        o_power_mode = `MODE_SLEEP;
        o_cpu_run = 1'b0;
        o_periph_on = 1'b0;
        o_periph_keep = 1'b0;
        o_ram_on = i_ram_retain;
      end
      pw_deep: begin
        o_power_mode = `MODE_DEEP;
        o_cpu_run = 1'b0;
        o_periph_on = 1'b0;
        o_periph_keep = 1'b0;
        o_radio_on = 1'b0;
        o_ram_on = 2'h0;
      end
      default: o_power_mode = `MODE_RUN;
    endcase
  end

  // ****************************************
  // Core reset and cause
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_core_reset <= 1'b1;
      o_reset_cause <= `CAUSE_POR;
    end else begin
      o_core_reset <= wake_pulse_sleep | wake_pulse_deep | i_watchdog_rst | i_software_rst;
      if (wake_pulse_deep) begin
        o_reset_cause <= `CAUSE_WAKE_DEEP;
      end else if (wake_pulse_sleep) begin
        o_reset_cause <= `CAUSE_WAKE_SLEEP;
      end else if (i_watchdog_rst) begin
        o_reset_cause <= `CAUSE_WATCHDOG;
      end else if (i_software_rst) begin
        o_reset_cause <= `CAUSE_SOFTWARE;
      end
    end
  end
  assign o_reset_vector = `RESET_VECTOR;

  // ****************************************
  // Clock selection and glitch-free switch
  // ****************************************
  switch_state_e sstate;
  logic [1:0] pend_src;
  logic [PRESCALE_W-1:0] pend_div;
  logic [1:0] edge_cnt;
  logic [MON_W-1:0] mon_cnt;
  logic mon_trip;
  assign mon_trip = i_mon_enable && (mon_cnt >= i_mon_limit) && !sys_edge;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sstate <= sw_idle;
      o_clk_src <= `SRC_RC_FAST;
      o_clk_div <= PRESCALE_W'(1);
      pend_src <= `SRC_RC_FAST;
      pend_div <= PRESCALE_W'(1);
      edge_cnt <= 2'h0;
      o_clk_gate <= 1'b1;
    end else if (mon_trip) begin
      sstate <= sw_idle;
      o_clk_src <= `SRC_RC_FAST;
      o_clk_div <= PRESCALE_W'(1);
      pend_src <= `SRC_RC_FAST;
      pend_div <= PRESCALE_W'(1);
      edge_cnt <= 2'h0;
      o_clk_gate <= 1'b1;
    end else begin
      if (i_clksel_wr) begin
        pend_src <= i_clksel_src;
        pend_div <= i_clksel_div;
      end
      case (sstate)
        sw_idle: begin
          if (i_clksel_wr) begin
            sstate <= sw_wait_start;
          end
        end
        sw_wait_start: begin
          if (osc_ready_s[pend_src]) begin
            sstate <= sw_old;
            edge_cnt <= 2'h0;
          end
        end
        sw_old: begin
          if (i_clksel_wr) begin
            sstate <= sw_wait_start;
          end else if (tick_seen[o_clk_src]) begin
            if (edge_cnt == `SWITCH_OLD_EDGES - 2'h1) begin
              o_clk_gate <= 1'b0;
              o_clk_src <= pend_src;
              o_clk_div <= pend_div;
              edge_cnt <= 2'h0;
              sstate <= sw_new;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        sw_new: begin
          if (tick_seen[o_clk_src]) begin
            if (edge_cnt == `SWITCH_NEW_EDGES - 2'h1) begin
              o_clk_gate <= 1'b1;
              sstate <= (i_clksel_wr || pend_src != o_clk_src || pend_div != o_clk_div) ?
                sw_wait_start : sw_idle;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        default: sstate <= sw_idle;
      endcase
    end
  end
  assign o_clk_switching = (sstate != sw_idle);
  always_comb begin
    o_osc_request = 4'h0;
    o_osc_request[o_clk_src] = 1'b1;
    if (sstate != sw_idle) begin
      o_osc_request[pend_src] = 1'b1;
    end
  end

  // ****************************************
  // Clock monitor
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mon_cnt <= '0;
      o_mon_tripped <= 1'b0;
    end else begin
      if (sys_edge || mon_trip || !i_mon_enable) begin
        mon_cnt <= '0;
      end else begin
        mon_cnt <= mon_cnt + MON_W'(1);
      end
      if (mon_trip) begin
        o_mon_tripped <= 1'b1;
      end else if (i_clksel_wr) begin
        o_mon_tripped <= 1'b0;
      end
    end
  end

  // ****************************************
  // Frequency-locked loop
  // ****************************************
  logic [15:0] rc_count;
  logic ref_running;
  assign ref_running = osc_ready_s[`SRC_FAST_XTAL] | osc_ready_s[`SRC_SLOW_XTAL];
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rc_count <= 16'h0000;
      o_rc_trim <= `TRIM_RESET;
    end else begin
      if (ref_edge) begin
        rc_count <= 16'h0000;
        if (i_fll_enable && ref_running) begin
          if (rc_count < i_fll_target && o_rc_trim != 8'hff) begin
            o_rc_trim <= o_rc_trim + `FLL_STEP;
          end else if (rc_count > i_fll_target && o_rc_trim != 8'h00) begin
            o_rc_trim <= o_rc_trim - `FLL_STEP;
          end
        end
      end else if (tick_seen[`SRC_RC_FAST] && rc_count != 16'hffff) begin
        rc_count <= rc_count + 16'h0001;
      end
      // Trim holds its last value when no reference edges arrive.
    end
  end

  // ****************************************
  // Scratch words survive every reset
  // ****************************************
  logic [7:0] scratch [4];
  always_ff @(posedge i_clk_sys) begin
    if (i_scratch_wr) begin
      scratch[i_scratch_sel] <= i_scratch_data;
    end
  end
  assign o_scratch = {scratch[3], scratch[2], scratch[1], scratch[0]};

  // ****************************************
  // Interrupt selection
  // ****************************************
  irq_vector_select #(
    .N(N_IRQ)
  ) u_irq (
    .i_pending(i_irq_pending),
    .i_enable(i_irq_enable),
    .i_high_prio(i_irq_high),
    .o_valid(o_irq_valid),
    .o_index(o_irq_index),
    .o_vector(o_irq_vector)
  );
endmodule
`default_nettype wire

//--- verif/sysctl_props.sv
// Checker of the system controller port behaviour.
`timescale 1ns/10ps
`default_nettype none
module sysctl_props (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Stimulus seen
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_ram_retain,
  input wire logic i_deep_wake_pin,
  input wire logic i_watchdog_rst,
  // Responses seen
  input wire logic [1:0] o_power_mode,
  input wire logic o_cpu_run,
  input wire logic o_periph_on,
  input wire logic o_radio_on,
  input wire logic [1:0] o_ram_on,
  input wire logic o_core_reset,
  input wire logic [2:0] o_reset_cause,
  input wire logic [1:0] o_clk_src,
  input wire logic o_clk_gate,
  input wire logic o_clk_switching,
  input wire logic o_mon_tripped,
  input wire logic o_irq_valid,
  input wire logic [4:0] o_irq_index,
  input wire logic [15:0] o_irq_vector
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  chk_vec_addr: assert property (o_irq_valid |->
    o_irq_vector == 16'h0003 + {8'h00, o_irq_index, 3'h0}) else $error("bad vector");
  chk_mode_take: assert property (i_mode_wr && o_power_mode == 2'h0 && i_mode != 2'h0
    |=> o_power_mode == $past(i_mode)) else $error("mode not taken");
  chk_sleep_state: assert property (o_power_mode == 2'h2 |->
    o_ram_on == i_ram_retain && !o_cpu_run && !o_periph_on) else $error("sleep state");
  chk_deep_state: assert property (o_power_mode == 2'h3 |->
    o_ram_on == 2'h0 && !o_radio_on && !o_cpu_run) else $error("deep state");
  chk_deep_exit: assert property ($past(o_power_mode) == 2'h3 && o_power_mode != 2'h3 |->
    !$past(i_deep_wake_pin, 1) || !$past(i_deep_wake_pin, 2) || !$past(i_deep_wake_pin, 3))
    else $error("deep exit without pin");
  chk_wake_cause: assert property ($past(o_power_mode) >= 2'h2 && o_power_mode == 2'h0
    |-> o_core_reset ##1 o_reset_cause == {1'b0, $past(o_power_mode, 2) - 2'h1})
    else $error("wake cause");
  chk_wdog_cause: assert property (i_watchdog_rst && o_power_mode == 2'h0
    |=> o_core_reset ##1 o_reset_cause == 3'h3) else $error("watchdog cause");
  chk_trip_restore: assert property ($rose(o_mon_tripped) |-> o_clk_src == 2'h2)
    else $error("trip did not restore");
  chk_gate_idle: assert property (!o_clk_switching |-> o_clk_gate)
    else $error("gate low while idle");
  cov_switch: cover property ($fell(o_clk_switching));
  cov_deep_exit: cover property ($past(o_power_mode) == 2'h3 && o_power_mode == 2'h0);
  cov_trip: cover property ($rose(o_mon_tripped));
  cov_irq: cover property (o_irq_valid && o_irq_index == 5'h15);
endmodule
bind system_power_clock_reset_ctrl sysctl_props props_u (.*);
`default_nettype wire

//--- verif/osc_model.sv
// Oscillators, crystal start-up and clock edge source around the controller.
`timescale 1ns/10ps
`default_nettype none
module osc_model (
  // Clock and controls
  input wire logic i_clk_sys,
  input wire logic i_stall,
  input wire logic i_ref_run,
  input wire logic [1:0] i_xtal_force,
  input wire logic [3:0] i_osc_request,
  // Oscillator views
  output logic [3:0] o_osc_tick = 4'h0,
  output logic [3:0] o_osc_ready,
  output logic o_sysclk_edge = 1'b0,
  output logic o_ref_tick = 1'b0
);
  // ****************************************
  // Oscillators
  // ****************************************
  logic [1:0][4:0] start_cnt = '0;
  always #131 o_osc_tick[0] = ~o_osc_tick[0];
  always #411 o_osc_tick[1] = ~o_osc_tick[1];
  always #71 o_osc_tick[2] = ~o_osc_tick[2];
  always #293 o_osc_tick[3] = ~o_osc_tick[3];
  always #1333 o_ref_tick = i_ref_run ? ~o_ref_tick : o_ref_tick;
  // Crystals need twenty cycles of demand before they report ready.
  always @(posedge i_clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (!(i_osc_request[i] || i_xtal_force[i]))
        start_cnt[i] <= 5'h00;
      else if (start_cnt[i] != 5'h14)
        start_cnt[i] <= start_cnt[i] + 5'h01;
    end
    o_sysclk_edge <= i_stall ? o_sysclk_edge : ~o_sysclk_edge;
  end
  assign o_osc_ready = {2'h3, start_cnt[1] == 5'h14, start_cnt[0] == 5'h14};
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench of the system power, clock and reset controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sysctl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_deep_wake_pin = 1'b1;
  logic i_mode_wr = 1'b0, i_clksel_wr = 1'b0, i_scratch_wr = 1'b0, i_port_irq = 1'b0;
  logic i_ctrl_irq = 1'b0, i_watchdog_rst = 1'b0, i_software_rst = 1'b0, i_mon_enable = 1'b0;
  logic i_fll_enable = 1'b0, stall = 1'b0, ref_run = 1'b0;
  logic [1:0] i_mode = 2'h0, i_ram_retain = 2'h0, i_clksel_src = 2'h0, i_scratch_sel = 2'h0;
  logic [1:0] xtal_force = 2'h0;
  logic [2:0] i_clksel_div = 3'h0;
  logic [7:0] i_scratch_data = 8'h00;
  logic [15:0] i_mon_limit = 16'h0008, i_fll_target = 16'h0000;
  logic [21:0] i_irq_pending = 22'h0, i_irq_enable = 22'h0, i_irq_high = 22'h0;
  logic [3:0] i_osc_tick, i_osc_ready, o_osc_request;
  logic i_sysclk_edge, i_ref_tick, o_cpu_run, o_periph_on, o_periph_keep, o_radio_on;
  logic o_core_reset, o_clk_gate, o_clk_switching, o_mon_tripped, o_irq_valid;
  logic [1:0] o_power_mode, o_ram_on, o_clk_src;
  logic [15:0] o_reset_vector, o_irq_vector;
  logic [2:0] o_reset_cause, o_clk_div;
  logic [7:0] o_rc_trim;
  logic [31:0] o_scratch;
  logic [4:0] o_irq_index;
  int seed = 32, error_cnt = 0, checked = 0;
  system_power_clock_reset_ctrl dut_u (.*);
  osc_model osc_u (.i_clk_sys, .i_stall(stall), .i_ref_run(ref_run), .i_xtal_force(xtal_force),
    .i_osc_request(o_osc_request), .o_osc_tick(i_osc_tick), .o_osc_ready(i_osc_ready),
    .o_sysclk_edge(i_sysclk_edge), .o_ref_tick(i_ref_tick));
  // ****************************************
  // Tasks
  // ****************************************
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic await(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++) cyc(1);
    check(s, v);
  endtask
  task mode_write(input logic [1:0] m);
    i_mode = m;
    i_mode_wr = 1'b1;
    cyc(1);
    i_mode_wr = 1'b0;
  endtask
  // Expected {valid, index, vector}: high level first, then lowest index.
  function automatic logic [21:0] irq_exp(input logic [21:0] p, e, h);
    logic [21:0] a;
    int k;
    a = (p & e & h) != 0 ? p & e & h : p & e;
    for (k = 0; k < 21 && !a[k]; k++);
    return {a != 0, 5'(k), 16'h0003 + 16'(k) * 16'h0008};
  endfunction
  task complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    for (int n = 0; n < 20000; n++) @(posedge i_clk_sys);
    error_cnt++;
    complete_run();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [21:0] r;
    logic [31:0] w;
    cyc(16);
    i_reset = 1'b0;
    cyc(1);
    check({o_power_mode, o_clk_src, o_clk_div, o_clk_switching}, 8'h22);
    check(o_reset_vector, 16'h0000);
    check(o_reset_cause, 3'h0);
    $display("done: defaults");
    for (int i = 0; i < 40; i++) begin
      i_irq_pending = i == 0 ? 22'h200000 : 22'($random(seed));
      i_irq_enable = i < 2 ? 22'h3fffff : 22'($random(seed));
      i_irq_high = i < 2 ? 22'h0 : 22'($random(seed));
      #1;
      r = irq_exp(i_irq_pending, i_irq_enable, i_irq_high);
      check(o_irq_valid, r[21]);
      if (r[21]) check({o_irq_index, o_irq_vector}, r[20:0]);
      cyc(1);
    end
    i_irq_pending = 22'h0;
    i_irq_enable = 22'h0;
    $display("done: irq");
    for (int i = 0; i < 2; i++) begin
      i_ram_retain = 2'($random(seed));
      mode_write(2'h2);
      check({o_power_mode, o_ram_on}, {2'h2, i_ram_retain});
      mode_write(2'h1);
      check(o_power_mode, 2'h2);
      i_port_irq = i[0];
      i_ctrl_irq = !i[0];
      await(o_core_reset, 1'b1);
      i_port_irq = 1'b0;
      i_ctrl_irq = 1'b0;
      cyc(1);
      check({o_power_mode, o_reset_cause}, 5'h01);
    end
    mode_write(2'h1);
    check({o_power_mode, o_cpu_run, o_periph_on, o_periph_keep}, 5'h0b);
    i_irq_pending = 22'h000020;
    cyc(4);
    check(o_power_mode, 2'h1);
    i_irq_enable = 22'h000020;
    cyc(2);
    check({o_power_mode, o_reset_cause}, 5'h01);
    i_irq_pending = 22'h0;
    mode_write(2'h3);
    check({o_power_mode, o_ram_on, o_radio_on, o_cpu_run}, 6'h30);
    i_port_irq = 1'b1;
    cyc(6);
    check(o_power_mode, 2'h3);
    i_port_irq = 1'b0;
    i_deep_wake_pin = 1'b0;
    await(o_core_reset, 1'b1);
    i_deep_wake_pin = 1'b1;
    cyc(1);
    check({o_power_mode, o_reset_cause}, 5'h02);
    for (int i = 0; i < 3; i++) begin
      i_watchdog_rst = i != 1;
      i_software_rst = i != 0;
      cyc(1);
      i_watchdog_rst = 1'b0;
      i_software_rst = 1'b0;
      check(o_core_reset, 1'b1);
      cyc(1);
      check(o_reset_cause, i == 1 ? 3'h4 : 3'h3);
    end
    $display("done: power");
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      i_clksel_src = 2'(i);
      i_clksel_div = w[2:0];
      i_clksel_wr = 1'b1;
      cyc(1);
      i_clksel_wr = 1'b0;
      check(o_clk_switching, 1'b1);
      cyc(10);
      if (i < 2) check(o_clk_switching, 1'b1);
      await(o_clk_switching, 1'b0);
      check({o_clk_src, o_clk_div, o_clk_gate, o_osc_request}, {2'(i), w[2:0], 1'b1, 4'h1 << i});
    end
    i_mon_enable = 1'b1;
    stall = 1'b1;
    await(o_mon_tripped, 1'b1);
    check({o_clk_src, o_clk_div}, 5'h11);
    stall = 1'b0;
    i_mon_enable = 1'b0;
    $display("done: clock");
    w = $random(seed);
    i_scratch_wr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_scratch_sel = 2'(i);
      i_scratch_data = w[8 * i +: 8];
      cyc(1);
    end
    i_scratch_wr = 1'b0;
    i_reset = 1'b1;
    cyc(2);
    i_reset = 1'b0;
    cyc(1);
    check(o_scratch, w);
    check({o_clk_src, o_clk_div, o_mon_tripped, o_rc_trim}, 14'h2280);
    xtal_force = 2'h1;
    i_fll_enable = 1'b1;
    ref_run = 1'b1;
    cyc(300);
    check(o_rc_trim < 8'h80, 1'b1);
    ref_run = 1'b0;
    cyc(10);
    w = o_rc_trim;
    cyc(60);
    check(o_rc_trim, w[7:0]);
    $display("done: scratch and trim");
    complete_run();
  end
endmodule
`default_nettype wire
